// ==== design/adcc_pkg.sv ====
package adcc_pkg;

    // register byte addresses on the bus
    localparam logic [7:0] ADCC_OFS_CTRL_STATUS = 8'h00;
    localparam logic [7:0] ADCC_OFS_TRIG_CLOCK  = 8'h04;
    localparam logic [7:0] ADCC_OFS_RESULT_0    = 8'h08;
    localparam logic [7:0] ADCC_OFS_RESULT_1    = 8'h0c;
    localparam logic [7:0] ADCC_OFS_RESULT_2    = 8'h10;
    localparam logic [7:0] ADCC_OFS_RESULT_3    = 8'h14;
    localparam logic [7:0] ADCC_OFS_IRQ_STATUS  = 8'h18;
    localparam logic [7:0] ADCC_OFS_IRQ_MASK    = 8'h1c;

    // control/status field positions
    localparam int ADCC_CSR_END_FLAG  = 7;
    localparam int ADCC_CSR_IRQ_EN    = 6;
    localparam int ADCC_CSR_START     = 5;
    localparam int ADCC_CSR_SCAN      = 4;
    localparam int ADCC_CSR_RSV3      = 3;
    localparam int ADCC_CSR_GROUP     = 2;

    // trigger/clock field positions and fixed reserved ones
    localparam int         ADCC_CR_TRIG_LSB = 6;
    localparam int         ADCC_CR_CKS_LSB  = 2;
    localparam logic [1:0] ADCC_CR_RSV_ONES = 2'h3;

    // trigger source codes
    localparam logic [1:0] ADCC_TRIG_SW    = 2'h0;
    localparam logic [1:0] ADCC_TRIG_TIMER = 2'h1;
    localparam logic [1:0] ADCC_TRIG_BAD   = 2'h2;
    localparam logic [1:0] ADCC_TRIG_EXT   = 2'h3;

    // interrupt status bits
    localparam int ADCC_IRQ_CONV_END = 0;
    localparam int ADCC_IRQ_CHAN_END = 1;

    // conversion length in states (one state is one clock), first and scan repeat
    localparam logic [9:0] ADCC_CONV_FIRST [4] = '{10'd530, 10'd266, 10'd134, 10'd68};
    localparam logic [9:0] ADCC_CONV_SCAN  [4] = '{10'd512, 10'd256, 10'd128, 10'd64};

    // result layout: 10 bits left aligned in 16
    localparam int ADCC_RES_W   = 10;
    localparam int ADCC_RES_LSB = 6;

    // reset values
    localparam logic [7:0] ADCC_CSR_RESET = 8'h00;
    localparam logic [1:0] ADCC_IRQ_RESET = 2'h0;

    // converter sequencer states
    typedef enum logic {ADCC_IDLE, ADCC_CONVERT} adcc_state_e;

endpackage

// ==== design/adcc_edge_det.sv ====
`timescale 1ns/1ps
`default_nettype none
// one-cycle pulse on a chosen edge of a synchronous input
module adcc_edge_det #(
    parameter bit FALLING = 1'b1
) (
    input  wire logic clk_i,
    input  wire logic rst_i,
    input  wire logic level_i,
    output logic      pulse_o
);
    logic prev_reg;

    // previous level, reset to the idle level of the chosen edge
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            prev_reg <= FALLING;
        end else begin
            prev_reg <= level_i;
        end
    end

    assign pulse_o = FALLING ? (prev_reg & ~level_i) : (~prev_reg & level_i);
endmodule
`default_nettype wire

// ==== design/adcc_conv_timer.sv ====
`timescale 1ns/1ps
`default_nettype none
// down counter of conversion states; done is high in the last state
module adcc_conv_timer (
    input  wire logic       clk_i,
    input  wire logic       rst_i,
    input  wire logic       load_i,
    input  wire logic       abort_i,
    input  wire logic [9:0] load_val_i,
    output logic            done_o
);
    logic [9:0] cnt_reg;

    // load wins over abort so a restart in the same cycle is kept
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cnt_reg <= 10'h000;
        end else if (load_i) begin
            cnt_reg <= load_val_i;
        end else if (abort_i) begin
            cnt_reg <= 10'h000;
        end else if (cnt_reg != 10'h000) begin
            cnt_reg <= cnt_reg - 10'h001;
        end
    end

    assign done_o = (cnt_reg == 10'h001) & ~abort_i;
endmodule
`default_nettype wire

// ==== design/adcc_top.sv ====
`timescale 1ns/1ps
`default_nettype none
module adcc_top
    import adcc_pkg::*;
#(
    parameter bit HAS_LOW_INPUTS = 1'b1
) (
    input  wire logic        SYS_CLK_I,
    input  wire logic        RST_I,
    input  wire logic        HSEL_I,
    input  wire logic [31:0] HADDR_I,
    input  wire logic [1:0]  HTRANS_I,
    input  wire logic        HWRITE_I,
    input  wire logic [2:0]  HSIZE_I,
    input  wire logic [31:0] HWDATA_I,
    input  wire logic        HREADY_I,
    output logic      [31:0] HRDATA_O,
    output logic             HREADYOUT_O,
    output logic             HRESP_O,
    input  wire logic        EXT_CONV_TRIGGER_PIN_I,
    input  wire logic        TIMER_PULSE_UNIT_TRIG_I,
    input  wire logic        STANDBY_I,
    input  wire logic        MODULE_STOP_I,
    input  wire logic [9:0]  CONV_RESULT_I,
    output logic      [2:0]  CONV_CHANNEL_O,
    output logic             CONV_BUSY_O,
    output logic             IRQ_O
);
    // bus side
    logic        dp_write_reg;
    logic [7:0]  dp_addr_reg;
    logic        addr_phase;
    logic        wr_csr;
    logic        wr_cr;
    logic        wr_istat;
    logic        wr_imask;
    logic [31:0] rdata_next;
    // registers
    logic        end_flag_reg;
    logic        irq_en_reg;
    logic        start_reg;
    logic        scan_reg;
    logic        rsv3_reg;
    logic [2:0]  chan_sel_reg;
    logic [1:0]  trig_src_reg;
    logic [1:0]  cks_reg;
    logic [9:0]  result_reg [4];
    logic [1:0]  irq_stat_reg;
    logic [1:0]  irq_mask_reg;
    // sequencer
    adcc_state_e state_reg;
    logic [1:0]  scan_idx_reg;
    logic        stop_req;
    logic        ext_fall;
    logic        timer_rise;
    logic        trig_start;
    logic        conv_done;
    logic        pass_done;
    logic        timer_load;
    logic [9:0]  timer_val;
    logic [1:0]  res_idx;
    logic [7:0]  csr_value;
    logic [7:0]  cr_value;

    // address phase of a selected transfer
    assign addr_phase = HSEL_I & HREADY_I & HTRANS_I[1];

    // capture address phase for the write data phase
    always_ff @(posedge SYS_CLK_I) begin
        if (RST_I) begin
            dp_write_reg <= 1'b0;
            dp_addr_reg  <= 8'h00;
        end else if (HREADY_I) begin
            dp_write_reg <= addr_phase & HWRITE_I;
            dp_addr_reg  <= HADDR_I[7:0];
        end
    end

    // zero wait state slave, always OKAY
    always_ff @(posedge SYS_CLK_I) begin
        if (RST_I) begin
            HREADYOUT_O <= 1'b0;
            HRESP_O     <= 1'b0;
        end else begin
            HREADYOUT_O <= 1'b1;
            HRESP_O     <= 1'b0;
        end
    end

    // write strobes in the data phase
    assign wr_csr   = dp_write_reg & (dp_addr_reg == ADCC_OFS_CTRL_STATUS);
    assign wr_cr    = dp_write_reg & (dp_addr_reg == ADCC_OFS_TRIG_CLOCK);
    assign wr_istat = dp_write_reg & (dp_addr_reg == ADCC_OFS_IRQ_STATUS);
    assign wr_imask = dp_write_reg & (dp_addr_reg == ADCC_OFS_IRQ_MASK);

    // register read images
    assign csr_value = {end_flag_reg, irq_en_reg, start_reg, scan_reg, rsv3_reg, chan_sel_reg};
    assign cr_value  = {trig_src_reg, ADCC_CR_RSV_ONES, cks_reg, ADCC_CR_RSV_ONES};

    // read mux, unmapped addresses read zero
    always_comb begin
        rdata_next = 32'h0000_0000;
        unique case (HADDR_I[7:0])
            ADCC_OFS_CTRL_STATUS: rdata_next = {24'h00_0000, csr_value};
            ADCC_OFS_TRIG_CLOCK:  rdata_next = {24'h00_0000, cr_value};
            ADCC_OFS_RESULT_0:    rdata_next = {16'h0000, result_reg[0], 6'h00};
            ADCC_OFS_RESULT_1:    rdata_next = {16'h0000, result_reg[1], 6'h00};
            ADCC_OFS_RESULT_2:    rdata_next = {16'h0000, result_reg[2], 6'h00};
            ADCC_OFS_RESULT_3:    rdata_next = {16'h0000, result_reg[3], 6'h00};
            ADCC_OFS_IRQ_STATUS:  rdata_next = {30'h0, irq_stat_reg};
            ADCC_OFS_IRQ_MASK:    rdata_next = {30'h0, irq_mask_reg};
            default:              rdata_next = 32'h0000_0000;
        endcase
    end

    // read data registered at the address phase, stands through the data phase
    always_ff @(posedge SYS_CLK_I) begin
        if (RST_I) begin
            HRDATA_O <= 32'h0000_0000;
        end else if (addr_phase & ~HWRITE_I) begin
            HRDATA_O <= rdata_next;
        end
    end

    // start sources gated by trigger selection; code 10 starts nothing
    adcc_edge_det #(.FALLING(1'b1)) u_ext_edge (
        .clk_i   (SYS_CLK_I),
        .rst_i   (RST_I),
        .level_i (EXT_CONV_TRIGGER_PIN_I),
        .pulse_o (ext_fall)
    );
    adcc_edge_det #(.FALLING(1'b0)) u_timer_edge (
        .clk_i   (SYS_CLK_I),
        .rst_i   (RST_I),
        .level_i (TIMER_PULSE_UNIT_TRIG_I),
        .pulse_o (timer_rise)
    );
    assign trig_start = ((trig_src_reg == ADCC_TRIG_EXT) & ext_fall) |
                        ((trig_src_reg == ADCC_TRIG_TIMER) & timer_rise);
    assign stop_req   = STANDBY_I | MODULE_STOP_I;

    // conversion timing from clock select; repeats in scan use the shorter ADCC_CONV_SCAN length for the same clock select
    assign timer_load = ((state_reg == ADCC_IDLE) & start_reg & ~stop_req) |
                        ((state_reg == ADCC_CONVERT) & conv_done & scan_reg & start_reg);
    assign timer_val  = (state_reg == ADCC_IDLE) ? ADCC_CONV_FIRST[cks_reg]
                                                 : ADCC_CONV_SCAN[cks_reg];
    adcc_conv_timer u_timer (
        .clk_i      (SYS_CLK_I),
        .rst_i      (RST_I),
        .load_i     (timer_load),
        .abort_i    (~start_reg),
        .load_val_i (timer_val),
        .done_o     (conv_done)
    );

    // end of one pass: single conversion, or last channel of the scan group
    assign pass_done = (state_reg == ADCC_CONVERT) & conv_done &
                       (~scan_reg | (scan_idx_reg == chan_sel_reg[1:0]));
    assign res_idx   = scan_reg ? scan_idx_reg : chan_sel_reg[1:0];

    // sequencer state follows the start bit
    always_ff @(posedge SYS_CLK_I) begin
        if (RST_I) begin
            state_reg <= ADCC_IDLE;
        end else if (~start_reg | stop_req) begin
            state_reg <= ADCC_IDLE;
        end else begin
            unique case (state_reg)
                ADCC_IDLE:    state_reg <= ADCC_CONVERT;
                ADCC_CONVERT: begin
                    if (conv_done & ~scan_reg) begin
                        state_reg <= ADCC_IDLE;
                    end
                end
            endcase
        end
    end

    // scan position always restarts at the group's first input
    always_ff @(posedge SYS_CLK_I) begin
        if (RST_I) begin
            scan_idx_reg <= 2'h0;
        end else if (state_reg == ADCC_IDLE) begin
            scan_idx_reg <= 2'h0;
        end else if (conv_done & scan_reg) begin
            scan_idx_reg <= pass_done ? 2'h0 : scan_idx_reg + 2'h1;
        end
    end

    // channel presented to the analog multiplexer
    always_ff @(posedge SYS_CLK_I) begin
        if (RST_I) begin
            CONV_CHANNEL_O <= 3'h0;
            CONV_BUSY_O    <= 1'b0;
        end else begin
            CONV_BUSY_O <= timer_load | ((state_reg == ADCC_CONVERT) & ~conv_done & start_reg);
            if (timer_load & (state_reg == ADCC_IDLE)) begin
                CONV_CHANNEL_O <= scan_reg ? {chan_sel_reg[2], 2'h0} : chan_sel_reg;
            end else if (timer_load) begin
                CONV_CHANNEL_O <= {chan_sel_reg[2], pass_done ? 2'h0 : scan_idx_reg + 2'h1};
            end
        end
    end

    // results; on a part without inputs 0 and 1 a single conversion of those writes nothing, while a scan stores
    // whatever the converter returns for the absent pins, so scan codes 000 to 011 leave them undefined
    always_ff @(posedge SYS_CLK_I) begin
        if (RST_I) begin
            for (int i = 0; i < 4; i++) begin
                result_reg[i] <= 10'h000;
            end
        end else if ((state_reg == ADCC_CONVERT) & conv_done) begin
            if (HAS_LOW_INPUTS | scan_reg | res_idx[1] | chan_sel_reg[2]) begin
                result_reg[res_idx] <= CONV_RESULT_I;
            end
        end
    end

    // start bit: stop sources win, then software, then triggers, then self clear
    always_ff @(posedge SYS_CLK_I) begin
        if (RST_I) begin
            start_reg <= ADCC_CSR_RESET[ADCC_CSR_START];
        end else if (stop_req) begin
            start_reg <= 1'b0;
        end else if (wr_csr) begin
            start_reg <= HWDATA_I[ADCC_CSR_START];
        end else if (trig_start) begin
            start_reg <= 1'b1;
        end else if (pass_done & ~scan_reg) begin
            start_reg <= 1'b0;
        end
    end

    // plain control bits of the control/status register
    always_ff @(posedge SYS_CLK_I) begin
        if (RST_I) begin
            irq_en_reg   <= ADCC_CSR_RESET[ADCC_CSR_IRQ_EN];
            scan_reg     <= ADCC_CSR_RESET[ADCC_CSR_SCAN];
            rsv3_reg     <= ADCC_CSR_RESET[ADCC_CSR_RSV3];
            chan_sel_reg <= ADCC_CSR_RESET[ADCC_CSR_GROUP:0];
        end else if (wr_csr) begin
            irq_en_reg   <= HWDATA_I[ADCC_CSR_IRQ_EN];
            scan_reg     <= HWDATA_I[ADCC_CSR_SCAN];
            rsv3_reg     <= HWDATA_I[ADCC_CSR_RSV3];
            chan_sel_reg <= HWDATA_I[ADCC_CSR_GROUP:0];
        end
    end

    // end flag: hardware set wins over a written 0, a written 1 is ignored
    always_ff @(posedge SYS_CLK_I) begin
        if (RST_I) begin
            end_flag_reg <= ADCC_CSR_RESET[ADCC_CSR_END_FLAG];
        end else if (pass_done) begin
            end_flag_reg <= 1'b1;
        end else if (wr_csr & ~HWDATA_I[ADCC_CSR_END_FLAG]) begin
            end_flag_reg <= 1'b0;
        end
    end

    // trigger and clock select; reserved bits are constants
    always_ff @(posedge SYS_CLK_I) begin
        if (RST_I) begin
            trig_src_reg <= ADCC_TRIG_SW;
            cks_reg      <= 2'h0;
        end else if (wr_cr) begin
            trig_src_reg <= HWDATA_I[ADCC_CR_TRIG_LSB +: 2];
            cks_reg      <= HWDATA_I[ADCC_CR_CKS_LSB +: 2];
        end
    end

    // sticky interrupt status, write one to clear, set wins
    always_ff @(posedge SYS_CLK_I) begin
        if (RST_I) begin
            irq_stat_reg <= ADCC_IRQ_RESET;
        end else begin
            for (int b = 0; b < 2; b++) begin
                if ((b == ADCC_IRQ_CONV_END) ? pass_done :
                        ((state_reg == ADCC_CONVERT) & conv_done)) begin
                    irq_stat_reg[b] <= 1'b1;
                end else if (wr_istat & HWDATA_I[b]) begin
                    irq_stat_reg[b] <= 1'b0;
                end
            end
        end
    end

    // interrupt mask
    always_ff @(posedge SYS_CLK_I) begin
        if (RST_I) begin
            irq_mask_reg <= ADCC_IRQ_RESET;
        end else if (wr_imask) begin
            irq_mask_reg <= HWDATA_I[1:0];
        end
    end

    // interrupt line: enabled end flag or any unmasked sticky event
    always_ff @(posedge SYS_CLK_I) begin
        if (RST_I) begin
            IRQ_O <= 1'b0;
        end else begin
            IRQ_O <= (end_flag_reg & irq_en_reg) | (|(irq_stat_reg & irq_mask_reg));
        end
    end

    // helper: cycles since a conversion was loaded
    logic [9:0] conv_age_reg;
    always_ff @(posedge SYS_CLK_I) begin
        if (RST_I | timer_load) begin
            conv_age_reg <= 10'h000;
        end else if (conv_age_reg != 10'h3ff) begin
            conv_age_reg <= conv_age_reg + 10'h001;
        end
    end
    logic [1:0] age_cks_reg;
    always_ff @(posedge SYS_CLK_I) begin
        if (RST_I) begin
            age_cks_reg <= 2'h0;
        end else if (timer_load) begin
            age_cks_reg <= cks_reg;
        end
    end

    default clocking @(posedge SYS_CLK_I); endclocking
    default disable iff (RST_I);

    AST_IRQ_NEEDS_CAUSE: assert property (
        IRQ_O & ~(|$past(irq_mask_reg & irq_stat_reg)) |-> $past(end_flag_reg & irq_en_reg)
    ) else $error("interrupt without enabled end flag");

    AST_STOP_ABORTS: assert property (
        wr_csr & ~HWDATA_I[ADCC_CSR_START] & ~trig_start
        |=> ##1 (state_reg == ADCC_IDLE) && !CONV_BUSY_O
    ) else $error("clearing start did not abort");

    AST_SINGLE_SELF_CLEAR: assert property (
        pass_done & ~scan_reg & ~wr_csr & ~trig_start |=> ~start_reg & end_flag_reg
    ) else $error("single mode start not cleared at end");

    AST_SCAN_CONTINUES: assert property (
        (state_reg == ADCC_CONVERT) & conv_done & scan_reg & ~wr_csr & ~stop_req
        |=> start_reg & (state_reg == ADCC_CONVERT) & CONV_BUSY_O
    ) else $error("scan stopped by itself");

    AST_SINGLE_CHANNEL: assert property (
        $rose(CONV_BUSY_O) & ~scan_reg & ~$past(wr_csr) |-> CONV_CHANNEL_O == chan_sel_reg
    ) else $error("single channel mismatch");

    AST_SCAN_CHANNEL: assert property (
        CONV_BUSY_O & scan_reg & $stable(chan_sel_reg)
        |-> CONV_CHANNEL_O[2] == chan_sel_reg[2] && CONV_CHANNEL_O[1:0] <= chan_sel_reg[1:0]
    ) else $error("scan channel outside group");

    AST_FLAG_ONE_IGNORED: assert property (
        end_flag_reg & wr_csr & HWDATA_I[ADCC_CSR_END_FLAG] |=> end_flag_reg
    ) else $error("written one cleared end flag");

    AST_START_SOURCE: assert property (
        $rose(start_reg) |-> $past(wr_csr) || ($past(trig_src_reg) != ADCC_TRIG_BAD &&
                              $past(trig_src_reg) != ADCC_TRIG_SW)
    ) else $error("start set by a disabled source");

    AST_CR_RESERVED: assert property (
        addr_phase & ~HWRITE_I & (HADDR_I[7:0] == ADCC_OFS_TRIG_CLOCK)
        |=> HRDATA_O[5:4] == 2'h3 && HRDATA_O[1:0] == 2'h3 && HRDATA_O[31:8] == 24'h0
    ) else $error("reserved control bits not read as one");

    AST_CONV_LENGTH: assert property (
        (state_reg == ADCC_CONVERT) & conv_done & ~scan_reg & ~timer_load
        |-> conv_age_reg == ADCC_CONV_FIRST[age_cks_reg] - 10'd1
    ) else $error("single conversion length wrong");

    AST_EXT_TRIGGER: assert property (
        ext_fall & (trig_src_reg == ADCC_TRIG_EXT) & ~wr_csr & ~stop_req |=> start_reg
    ) else $error("pin edge did not set start");

    AST_RESULT_ALIGN: assert property (
        addr_phase & ~HWRITE_I & (HADDR_I[7:0] == ADCC_OFS_RESULT_2) |=> HRDATA_O[5:0] == 6'h00
        && HRDATA_O[15:6] == $past(result_reg[2])
    ) else $error("result not left aligned");
endmodule
`default_nettype wire

// ==== testbench/adcc_top_test.sv ====
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, ex, gt) begin cmp_count++; if ((gt) !== (ex)) begin error_cnt++; \
    $display("CHECK FAILED %s exp %0h got %0h", nm, ex, gt); end end
module adcc_top_test;
    import adcc_pkg::*;
    logic        clk = 1'b0;
    logic        rst = 1'b1;
    logic        hsel = 1'b0;
    logic        hwrite = 1'b0;
    logic [1:0]  htrans = 2'h0;
    logic [31:0] haddr = 32'h0;
    logic [31:0] hwdata = 32'h0;
    logic [31:0] rdata;
    logic        rdy;
    logic        resp;
    logic        ext = 1'b1;
    logic        tmr = 1'b0;
    logic        stby = 1'b0;
    logic        mstop = 1'b0;
    logic [9:0]  cres = 10'h0;
    logic [2:0]  chn;
    logic        busy;
    logic        irq;
    logic [31:0] q;
    logic [2:0]  ch;
    logic [2:0]  chs;
    logic [9:0]  res;
    logic        ie;
    logic [2:0]  seen [$];
    int          error_cnt = 0;
    int          cmp_count = 0;
    int          n;
    int          tconv [4] = '{530, 266, 134, 68};
    adcc_top u_dut (.SYS_CLK_I(clk), .RST_I(rst), .HSEL_I(hsel), .HADDR_I(haddr),
        .HTRANS_I(htrans), .HWRITE_I(hwrite), .HSIZE_I(3'h2), .HWDATA_I(hwdata),
        .HREADY_I(rdy), .HRDATA_O(rdata), .HREADYOUT_O(rdy), .HRESP_O(resp),
        .EXT_CONV_TRIGGER_PIN_I(ext), .TIMER_PULSE_UNIT_TRIG_I(tmr), .STANDBY_I(stby),
        .MODULE_STOP_I(mstop), .CONV_RESULT_I(cres), .CONV_CHANNEL_O(chn),
        .CONV_BUSY_O(busy), .IRQ_O(irq));
    // free running system clock
    always #50 clk = ~clk;
    // verdict and end of run
    task automatic complete_run;
        $display("compares %0d errors %0d", cmp_count, error_cnt);
        if (error_cnt == 0 && cmp_count > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    // one single word transfer, held until hready is sampled high
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        int k;
        k = 0;
        hsel <= 1'b1;
        htrans <= 2'h2;
        hwrite <= w;
        haddr <= {24'h0, a};
        do begin
            @(posedge clk);
            k++;
        end while (rdy !== 1'b1 && k < 50);
        htrans <= 2'h0;
        hwdata <= d;
        do begin
            @(posedge clk);
            k++;
        end while (rdy !== 1'b1 && k < 50);
        q = rdata;
        `CHK("hresp", 1'b0, resp)
        if (k >= 50) begin
            error_cnt++;
            complete_run();
        end
    endtask
    // waits for one conversion and counts its busy states
    task automatic run_conv;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (busy !== 1'b1 && n < 20);
        if (busy !== 1'b1) begin
            error_cnt++;
            complete_run();
        end
        chs = chn;
        n = 0;
        while (busy === 1'b1 && n < 1000) begin
            n++;
            @(posedge clk);
        end
        if (n >= 1000) begin
            error_cnt++;
            complete_run();
        end
    endtask
    // main sequence
    initial begin
        void'($urandom(72032));
        repeat (20) @(posedge clk);
        rst <= 1'b0;
        repeat (2) @(posedge clk);
        bus(0, ADCC_OFS_CTRL_STATUS, 0);
        `CHK("csr reset", 32'h0, q)
        bus(0, ADCC_OFS_TRIG_CLOCK, 0);
        `CHK("cr reset", 32'h33, q)
        bus(1, ADCC_OFS_TRIG_CLOCK, 32'hcc);
        bus(0, ADCC_OFS_TRIG_CLOCK, 0);
        `CHK("cr fixed ones", 32'hff, q)
        bus(0, 8'h20, 0);
        `CHK("unmapped", 32'h0, q)
        // single conversions over every clock code
        for (int c = 0; c < 4; c++) begin
            ch = {1'($urandom), 2'(c)};
            res = 10'($urandom);
            ie = (c != 3);
            cres <= res;
            bus(1, ADCC_OFS_TRIG_CLOCK, 32'(c << 2));
            bus(1, ADCC_OFS_CTRL_STATUS, {24'h0, 1'b0, ie, 3'b100, ch});
            run_conv();
            `CHK("conv states", tconv[c], n)
            `CHK("channel", ch, chs)
            repeat (2) @(posedge clk);
            `CHK("irq level", ie, irq)
            bus(0, ADCC_OFS_CTRL_STATUS, 0);
            `CHK("csr done", {24'h0, 2'b11 & {1'b1, ie}, 3'b000, ch}, q)
            bus(0, ADCC_OFS_RESULT_0 + 8'(4 * ch[1:0]), 0);
            `CHK("result", {16'h0, res, 6'h0}, q)
            bus(1, ADCC_OFS_CTRL_STATUS, {24'h0, 1'b1, ie, 3'b000, ch});
            bus(0, ADCC_OFS_CTRL_STATUS, 0);
            `CHK("flag kept", 1'b1, q[7])
            bus(1, ADCC_OFS_CTRL_STATUS, {24'h0, 1'b0, ie, 3'b000, ch});
            bus(0, ADCC_OFS_CTRL_STATUS, 0);
            `CHK("flag cleared", 1'b0, q[7])
            `CHK("irq cleared", 1'b0, irq)
        end
        // scan of group 1, two channels, shortest clock
        seen = {};
        bus(1, ADCC_OFS_IRQ_STATUS, 32'h3);
        bus(1, ADCC_OFS_CTRL_STATUS, 32'h35);
        for (int i = 0; i < 300; i++) begin
            @(posedge clk);
            if (busy === 1'b1 && (seen.size() == 0 || seen[$] !== chn)) seen.push_back(chn);
        end
        `CHK("scan steps", 1'b1, seen.size() >= 3)
        for (int i = 0; i < 3 && i < seen.size(); i++) begin
            `CHK("scan channel", 3'(4 + i % 2), seen[i])
        end
        bus(0, ADCC_OFS_CTRL_STATUS, 0);
        `CHK("scan csr", 32'hb5, q)
        bus(0, ADCC_OFS_IRQ_STATUS, 0);
        `CHK("irq status", 32'h3, q)
        `CHK("irq masked", 1'b0, irq)
        bus(1, ADCC_OFS_IRQ_MASK, 32'h3);
        repeat (2) @(posedge clk);
        `CHK("irq unmasked", 1'b1, irq)
        bus(1, ADCC_OFS_CTRL_STATUS, 32'h0);
        repeat (2) @(posedge clk);
        `CHK("abort", 1'b0, busy)
        bus(1, ADCC_OFS_IRQ_STATUS, 32'h3);
        repeat (2) @(posedge clk);
        `CHK("irq w1c", 1'b0, irq)
        bus(1, ADCC_OFS_IRQ_MASK, 32'h0);
        // every trigger source code against both trigger inputs
        for (int t = 0; t < 4; t++) begin
            bus(1, ADCC_OFS_TRIG_CLOCK, 32'(t << 6));
            ext <= 1'b0;
            tmr <= 1'b1;
            repeat (4) @(posedge clk);
            `CHK("trigger start", (t == 1 || t == 3), busy)
            ext <= 1'b1;
            tmr <= 1'b0;
            bus(1, ADCC_OFS_CTRL_STATUS, 32'h0);
            repeat (2) @(posedge clk);
            `CHK("trigger abort", 1'b0, busy)
        end
        // standby and module stop end a running scan
        for (int s = 0; s < 2; s++) begin
            bus(1, ADCC_OFS_CTRL_STATUS, 32'h35);
            repeat (5) @(posedge clk);
            stby <= (s == 0);
            mstop <= (s == 1);
            repeat (3) @(posedge clk);
            `CHK("stop busy", 1'b0, busy)
            stby <= 1'b0;
            mstop <= 1'b0;
            bus(0, ADCC_OFS_CTRL_STATUS, 0);
            `CHK("stop start bit", 1'b0, q[5])
        end
        complete_run();
    end
endmodule
`default_nettype wire
